// ---- hdl/dmrc_top.sv ----
// Behaviour
// - Any change of the mode field resets both converters at once.
// - A mode write with the same value also resets both, except the auxiliary-only case.
// - Writing primary control while primary enabled, or enabling primary, resets both.
// - Writing auxiliary control, or enabling auxiliary alone, resets only the auxiliary converter.
// - After an auxiliary-only reset, auxiliary results fall into step with primary outputs.
// - Writing a calibration mode clears both ready flags and starts calibration.
// - Calibration end writes coefficients, updates flags and returns the mode to 000.
// - Auxiliary calibration on the temperature sensor sets ready and error, no coefficients.
// - Calibration always runs with the maximum filter word.
// - Primary control bit 6 picks external (1) or internal bandgap (0) reference.
// - Primary control bits 5:4 pick the primary differential input pair.
// - Primary control bit 3 set gives unipolar coding, clear gives bipolar.
// - Primary control bits 2:0 pick the primary input range in doubling steps.
// - The auxiliary converter has no range field and runs on a fixed bipolar span.
// - Mode codes: power-down, idle, single, continuous, then four calibrations.
// - Single conversion ends by writing 000 to the mode field.
// - Auxiliary channel code 10 is the temperature sensor.
`timescale 1ns/1ns
`default_nettype none
module dmrc_top (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  // special function register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // from the filters
  input  wire logic [7:0] filter_rate_word_i,
  input  wire logic       prim_out_i,
  input  wire logic       aux_out_i,
  input  wire logic       cal_done_i,
  // converter control
  output logic            prim_reset_o,
  output logic            aux_reset_o,
  output logic            aux_hold_o,
  output logic            aux_valid_o,
  output logic      [2:0] conversion_mode_field_o,
  output logic            primary_converter_enable_o,
  output logic            auxiliary_converter_enable_o,
  output logic      [7:0] filter_word_o,
  // primary and auxiliary configuration
  output logic            primary_external_reference_select_o,
  output logic      [1:0] primary_input_pair_select_o,
  output logic            primary_unipolar_coding_o,
  output logic      [2:0] primary_range_select_o,
  output logic      [7:0] auxiliary_converter_control_o,
  // calibration
  output logic            cal_active_o,
  output logic      [1:0] cal_kind_o,
  output logic            prim_ofs_wr_o,
  output logic            prim_gain_wr_o,
  output logic            aux_ofs_wr_o,
  output logic            aux_gain_wr_o
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  // software registers
  logic [7:0] mode_ff,  nxt_mode;
  logic [7:0] ctl0_ff,  nxt_ctl0;
  logic [7:0] ctl1_ff,  nxt_ctl1;
  logic [7:0] stat_ff,  nxt_stat;

  // bus and filter outputs
  logic [7:0] rdata_ff, nxt_rdata;
  logic [7:0] fw_ff,    nxt_fw;

  // one-cycle pulses
  logic       prst_ff,  nxt_prst;
  logic       arst_ff,  nxt_arst;
  logic       start_ff, nxt_start;

  // decoded writes
  logic       wr_mode;
  logic       wr_ctl0;
  logic       wr_ctl1;
  logic       wr_stat;

  // mode write analysis
  logic [7:0] wmode;
  logic       en0_rise;
  logic       en1_rise;
  logic       aux_only;

  // converter activity
  logic       aux_vld;
  logic       prim_active;

  // handshake between control and calibration sequencer
  dmrc_cal_if cal ();

  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  assign wr_mode  = sfr_wr_i && (sfr_addr_i == dmrc_pkg::MODE_ADDR);
  assign wr_ctl0  = sfr_wr_i && (sfr_addr_i == dmrc_pkg::CTL0_ADDR);
  assign wr_ctl1  = sfr_wr_i && (sfr_addr_i == dmrc_pkg::CTL1_ADDR);
  assign wr_stat  = sfr_wr_i && (sfr_addr_i == dmrc_pkg::STAT_ADDR);

  assign wmode    = sfr_wdata_i & dmrc_pkg::MODE_MASK;
  assign en0_rise = wmode[dmrc_pkg::EN0_BIT] && !mode_ff[dmrc_pkg::EN0_BIT];
  assign en1_rise = wmode[dmrc_pkg::EN1_BIT] && !mode_ff[dmrc_pkg::EN1_BIT];

  // only turning the auxiliary on, mode bits and primary untouched
  assign aux_only = en1_rise && !en0_rise
                    && (wmode[2:0] == mode_ff[2:0])
                    && (wmode[dmrc_pkg::EN0_BIT] == mode_ff[dmrc_pkg::EN0_BIT]);

  // primary strobes count only while it converts
  assign prim_active = mode_ff[dmrc_pkg::EN0_BIT]
                       && ((mode_ff[2:0] == dmrc_pkg::MD_SINGLE)
                           || (mode_ff[2:0] == dmrc_pkg::MD_CONT));

  // ---------------------------------------------
  // register and control next state
  // ---------------------------------------------
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_ctl0  = ctl0_ff;
    nxt_ctl1  = ctl1_ff;
    nxt_stat  = stat_ff;
    nxt_prst  = 1'b0;
    nxt_arst  = 1'b0;
    nxt_start = 1'b0;
    nxt_rdata = rdata_ff;

    // status bits clear where a one is written
    if (wr_stat) begin
      nxt_stat = stat_ff & ~sfr_wdata_i;
    end

    if (wr_ctl0) begin
      nxt_ctl0 = sfr_wdata_i & dmrc_pkg::CTL_MASK;
      if (mode_ff[dmrc_pkg::EN0_BIT]) begin
        nxt_prst = 1'b1;
        nxt_arst = 1'b1;
      end
    end

    // auxiliary changes leave the primary running
    if (wr_ctl1) begin
      nxt_ctl1 = sfr_wdata_i & dmrc_pkg::CTL_MASK;
      nxt_arst = 1'b1;
    end

    if (wr_mode) begin
      nxt_mode = wmode;
      nxt_arst = 1'b1;
      if (!aux_only) begin
        nxt_prst = 1'b1;
      end
      if (wmode[2]) begin
        nxt_start = 1'b1;
      end
    end

    // hardware sets win over software clears
    if (prim_out_i && prim_active) begin
      nxt_stat[dmrc_pkg::PRIMARY_RESULT_READY_FLAG_BIT] = 1'b1;
      if (mode_ff[2:0] == dmrc_pkg::MD_SINGLE && !wr_mode) begin
        nxt_mode[2:0] = dmrc_pkg::MD_PDOWN;
      end
    end

    // an auxiliary-only single conversion also ends in power-down
    if (aux_vld) begin
      nxt_stat[dmrc_pkg::AUXILIARY_RESULT_READY_FLAG_BIT] = 1'b1;
      if (mode_ff[2:0] == dmrc_pkg::MD_SINGLE && !wr_mode
          && !mode_ff[dmrc_pkg::EN0_BIT]) begin
        nxt_mode[2:0] = dmrc_pkg::MD_PDOWN;
      end
    end

    if (cal.set_primary_result_ready_flag) begin
      nxt_stat[dmrc_pkg::PRIMARY_RESULT_READY_FLAG_BIT] = 1'b1;
    end

    if (cal.set_auxiliary_result_ready_flag) begin
      nxt_stat[dmrc_pkg::AUXILIARY_RESULT_READY_FLAG_BIT] = 1'b1;
    end

    if (cal.set_auxiliary_error_flag) begin
      nxt_stat[dmrc_pkg::AUXILIARY_ERROR_FLAG_BIT] = 1'b1;
    end

    // a new mode write outranks the automatic return to power-down
    if (cal.done && !wr_mode) begin
      nxt_mode[2:0] = dmrc_pkg::MD_PDOWN;
    end

    // calibration start clears both ready flags over any same-cycle set
    if (wr_mode && wmode[2]) begin
      nxt_stat[dmrc_pkg::PRIMARY_RESULT_READY_FLAG_BIT] = 1'b0;
      nxt_stat[dmrc_pkg::AUXILIARY_RESULT_READY_FLAG_BIT] = 1'b0;
    end

    // read data held until the next read
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        dmrc_pkg::MODE_ADDR: nxt_rdata = mode_ff;
        dmrc_pkg::CTL0_ADDR: nxt_rdata = ctl0_ff;
        dmrc_pkg::CTL1_ADDR: nxt_rdata = ctl1_ff;
        dmrc_pkg::STAT_ADDR: nxt_rdata = stat_ff;
        default:             nxt_rdata = 8'h00;
      endcase
    end
  end

  // calibration always at the slowest filter setting
  always_comb begin
    nxt_fw = cal.busy ? dmrc_pkg::SF_MAX : filter_rate_word_i;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_ff  <= dmrc_pkg::MODE_RST;
      ctl0_ff  <= dmrc_pkg::CTL0_RST;
      ctl1_ff  <= dmrc_pkg::CTL1_RST;
      stat_ff  <= dmrc_pkg::STAT_RST;
      rdata_ff <= 8'h00;
      fw_ff    <= 8'h00;
      prst_ff  <= 1'b0;
      arst_ff  <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      mode_ff  <= nxt_mode;
      ctl0_ff  <= nxt_ctl0;
      ctl1_ff  <= nxt_ctl1;
      stat_ff  <= nxt_stat;
      rdata_ff <= nxt_rdata;
      fw_ff    <= nxt_fw;
      prst_ff  <= nxt_prst;
      arst_ff  <= nxt_arst;
      start_ff <= nxt_start;
    end
  end

  // ---------------------------------------------
  // calibration sequencer and auxiliary alignment
  // ---------------------------------------------
  // kind and enables sampled from the mode register, which holds during the run
  assign cal.start    = start_ff;
  assign cal.kind     = mode_ff[1:0];
  assign cal.en0      = mode_ff[dmrc_pkg::EN0_BIT];
  assign cal.en1      = mode_ff[dmrc_pkg::EN1_BIT];
  assign cal.aux_temp = (ctl1_ff[dmrc_pkg::PAIR_LSB +: 2] == dmrc_pkg::ACH_TEMP);

  dmrc_cal_seq u_cal (
    .mclk_i         (mclk_i),
    .reset_n_i      (reset_n_i),
    .cal            (cal.seq),
    .cal_done_i     (cal_done_i),
    .prim_ofs_wr_o  (prim_ofs_wr_o),
    .prim_gain_wr_o (prim_gain_wr_o),
    .aux_ofs_wr_o   (aux_ofs_wr_o),
    .aux_gain_wr_o  (aux_gain_wr_o)
  );

  dmrc_aux_sync u_aux (
    .mclk_i        (mclk_i),
    .reset_n_i     (reset_n_i),
    .aux_rst_i     (arst_ff && !prst_ff),
    .prim_active_i (prim_active),
    .prim_out_i    (prim_out_i),
    .aux_out_i     (aux_out_i && mode_ff[dmrc_pkg::EN1_BIT]),
    .aux_hold_o    (aux_hold_o),
    .aux_valid_o   (aux_vld)
  );

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  // register port
  assign sfr_rdata_o                         = rdata_ff;

  // converter control
  assign prim_reset_o                        = prst_ff;
  assign aux_reset_o                         = arst_ff;
  assign aux_valid_o                         = aux_vld;
  assign conversion_mode_field_o             = mode_ff[2:0];
  assign primary_converter_enable_o          = mode_ff[dmrc_pkg::EN0_BIT];
  assign auxiliary_converter_enable_o        = mode_ff[dmrc_pkg::EN1_BIT];
  assign filter_word_o                       = fw_ff;

  // primary configuration
  assign primary_external_reference_select_o = ctl0_ff[dmrc_pkg::XREF_BIT];
  assign primary_input_pair_select_o         = ctl0_ff[dmrc_pkg::PAIR_LSB +: 2];
  assign primary_unipolar_coding_o           = ctl0_ff[dmrc_pkg::UNI_BIT];
  assign primary_range_select_o              = ctl0_ff[dmrc_pkg::RANGE_LSB +: 3];
  // auxiliary span is fixed; its control byte carries no range bits
  assign auxiliary_converter_control_o       = ctl1_ff;

  // calibration
  assign cal_active_o                        = cal.busy;
  assign cal_kind_o                          = mode_ff[1:0];
endmodule // dmrc_top
`default_nettype wire

// ---- pkg/dmrc_pkg.sv ----
package dmrc_pkg;
  // ---------------------------------------------
  // register addresses
  // ---------------------------------------------
  localparam logic [7:0] MODE_ADDR   = 8'hD1;
  localparam logic [7:0] CTL0_ADDR   = 8'hD2;
  localparam logic [7:0] CTL1_ADDR   = 8'hD3;
  localparam logic [7:0] STAT_ADDR   = 8'hD8;
  // ---------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------
  localparam logic [7:0] MODE_RST    = 8'h00;
  localparam logic [7:0] CTL0_RST    = 8'h07;
  localparam logic [7:0] CTL1_RST    = 8'h00;
  localparam logic [7:0] STAT_RST    = 8'h00;
  localparam logic [7:0] MODE_MASK   = 8'h37;
  localparam logic [7:0] CTL_MASK    = 8'h7F;
  // ---------------------------------------------
  // field positions
  // ---------------------------------------------
  localparam int         EN0_BIT     = 5;
  localparam int         EN1_BIT     = 4;
  localparam int         XREF_BIT    = 6;
  localparam int         PAIR_LSB    = 4;
  localparam int         UNI_BIT     = 3;
  localparam int         RANGE_LSB   = 0;
  localparam int         PRIMARY_RESULT_READY_FLAG_BIT    = 7;
  localparam int         AUXILIARY_RESULT_READY_FLAG_BIT    = 6;
  localparam int         AUXILIARY_ERROR_FLAG_BIT    = 4;
  // ---------------------------------------------
  // codes
  // ---------------------------------------------
  localparam logic [2:0] MD_PDOWN    = 3'h0;
  localparam logic [2:0] MD_IDLE     = 3'h1;
  localparam logic [2:0] MD_SINGLE   = 3'h2;
  localparam logic [2:0] MD_CONT     = 3'h3;
  localparam logic [1:0] ACH_TEMP    = 2'h2;
  localparam logic [7:0] SF_MAX      = 8'hFF;
endpackage

// ---- pkg/dmrc_cal_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface dmrc_cal_if;
  logic       start;
  logic [1:0] kind;
  logic       en0;
  logic       en1;
  logic       aux_temp;
  logic       busy;
  logic       done;
  logic       set_primary_result_ready_flag;
  logic       set_auxiliary_result_ready_flag;
  logic       set_auxiliary_error_flag;
  modport ctl (output start, kind, en0, en1, aux_temp,
               input  busy, done, set_primary_result_ready_flag, set_auxiliary_result_ready_flag, set_auxiliary_error_flag);
  modport seq (input  start, kind, en0, en1, aux_temp,
               output busy, done, set_primary_result_ready_flag, set_auxiliary_result_ready_flag, set_auxiliary_error_flag);
endinterface
`default_nettype wire

// ---- hdl/dmrc_cal_seq.sv ----
`timescale 1ns/1ns
`default_nettype none
module dmrc_cal_seq (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  // control side
  dmrc_cal_if.seq   cal,
  // filter side
  input  wire logic cal_done_i,
  output logic      prim_ofs_wr_o,
  output logic      prim_gain_wr_o,
  output logic      aux_ofs_wr_o,
  output logic      aux_gain_wr_o
);
  typedef enum logic [0:0] {
    DMRC_CAL_IDLE = 1'b0,
    DMRC_CAL_RUN  = 1'b1
  } dmrc_cal_st_t;

  dmrc_cal_st_t st_ff, nxt_st;
  logic [5:0]   evt_ff, nxt_evt;

  always_comb begin
    nxt_st  = st_ff;
    nxt_evt = 6'h00;
    case (st_ff)
      DMRC_CAL_IDLE: begin
        if (cal.start) begin
          nxt_st = DMRC_CAL_RUN;
        end
      end
      DMRC_CAL_RUN: begin
        if (cal.start) begin
          nxt_st = DMRC_CAL_RUN;
        end else if (cal_done_i) begin
          nxt_st = DMRC_CAL_IDLE;
          // kind bit 0 high means full scale, gain coefficient
          nxt_evt[0] = cal.en0 && !cal.kind[0];
          nxt_evt[1] = cal.en0 && cal.kind[0];
          // temp sensor input: coefficients untouched, flag error
          nxt_evt[2] = cal.en1 && !cal.aux_temp && !cal.kind[0];
          nxt_evt[3] = cal.en1 && !cal.aux_temp && cal.kind[0];
          nxt_evt[4] = cal.en1 && cal.aux_temp;
          nxt_evt[5] = 1'b1;
        end
      end
      default: nxt_st = DMRC_CAL_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff  <= DMRC_CAL_IDLE;
      evt_ff <= 6'h00;
    end else begin
      st_ff  <= nxt_st;
      evt_ff <= nxt_evt;
    end
  end

  assign prim_ofs_wr_o  = evt_ff[0];
  assign prim_gain_wr_o = evt_ff[1];
  assign aux_ofs_wr_o   = evt_ff[2];
  assign aux_gain_wr_o  = evt_ff[3];
  assign cal.set_auxiliary_error_flag   = evt_ff[4];
  assign cal.done       = evt_ff[5];
  assign cal.set_primary_result_ready_flag   = evt_ff[5] && cal.en0;
  assign cal.set_auxiliary_result_ready_flag   = evt_ff[5] && cal.en1;
  assign cal.busy       = (st_ff == DMRC_CAL_RUN);
endmodule // dmrc_cal_seq
`default_nettype wire

// ---- hdl/dmrc_aux_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module dmrc_aux_sync (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  // events
  input  wire logic aux_rst_i,
  input  wire logic prim_active_i,
  input  wire logic prim_out_i,
  input  wire logic aux_out_i,
  // aligned outputs
  output logic      aux_hold_o,
  output logic      aux_valid_o
);
  logic hold_ff, nxt_hold;
  logic pend_ff, nxt_pend;
  logic vld_ff,  nxt_vld;

  // while the primary converts, aux results are released only on primary output strobes
  always_comb begin
    nxt_hold = hold_ff;
    nxt_pend = pend_ff || aux_out_i;
    nxt_vld  = 1'b0;
    if (aux_rst_i) begin
      nxt_hold = prim_active_i;
      nxt_pend = 1'b0;
    end else if (!prim_active_i) begin
      nxt_hold = 1'b0;
      nxt_vld  = aux_out_i && !hold_ff;
      nxt_pend = 1'b0;
    end else if (prim_out_i) begin
      nxt_hold = 1'b0;
      nxt_vld  = nxt_pend && !hold_ff;
      nxt_pend = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_ff <= 1'b0;
      pend_ff <= 1'b0;
      vld_ff  <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      pend_ff <= nxt_pend;
      vld_ff  <= nxt_vld;
    end
  end

  assign aux_hold_o  = hold_ff;
  assign aux_valid_o = vld_ff;
endmodule // dmrc_aux_sync
`default_nettype wire

// ---- verif/dmrc_filter_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module dmrc_filter_model #(
  parameter int PER = 12
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  // from the block
  input  wire logic slow_i,
  input  wire logic prim_run_i,
  input  wire logic aux_run_i,
  input  wire logic cal_i,
  // filter strobes
  output logic      prim_out_o,
  output logic      aux_out_o,
  output logic      cal_done_o
);
  int cnt;
  int ccnt;
  // slow doubles the count limit (output period 13 to 25 cycles) and stretches calibration
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt        <= 0;
      ccnt       <= 0;
      prim_out_o <= 1'b0;
      aux_out_o  <= 1'b0;
      cal_done_o <= 1'b0;
    end else begin
      cnt        <= (cnt >= (slow_i ? 2 * PER : PER)) ? 0 : cnt + 1;
      ccnt       <= cal_i ? ccnt + 1 : 0;
      prim_out_o <= prim_run_i && cnt == 3;
      aux_out_o  <= aux_run_i && cnt == 7;
      cal_done_o <= cal_i && ccnt == (slow_i ? 20 : 6);
    end
  end
endmodule // dmrc_filter_model
`default_nettype wire

// ---- verif/dmrc_top_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module dmrc_top_asserts (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       reset_n_i,
  // register port and filters
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       prim_out_i,
  input wire logic       cal_done_i,
  // converter side
  input wire logic       prim_reset_o,
  input wire logic       aux_reset_o,
  input wire logic       aux_hold_o,
  input wire logic [2:0] conversion_mode_field_o,
  input wire logic       primary_converter_enable_o,
  input wire logic       auxiliary_converter_enable_o,
  input wire logic [7:0] filter_word_o,
  input wire logic       primary_external_reference_select_o,
  input wire logic [1:0] primary_input_pair_select_o,
  input wire logic       primary_unipolar_coding_o,
  input wire logic [2:0] primary_range_select_o,
  input wire logic [7:0] auxiliary_converter_control_o,
  input wire logic       cal_active_o,
  input wire logic [1:0] cal_kind_o,
  input wire logic       prim_ofs_wr_o,
  input wire logic       prim_gain_wr_o,
  input wire logic       aux_ofs_wr_o,
  input wire logic       aux_gain_wr_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic mode_wr;
  logic en1_only;
  // a write that only raises the auxiliary enable spares the primary
  assign mode_wr  = sfr_wr_i && sfr_addr_i == dmrc_pkg::MODE_ADDR;
  assign en1_only = sfr_wdata_i[2:0] == conversion_mode_field_o && sfr_wdata_i[4]
                    && sfr_wdata_i[5] == primary_converter_enable_o
                    && !auxiliary_converter_enable_o;
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  sequence s_cal_end;
    cal_active_o && cal_done_i;
  endsequence
  sequence s_cal_run;
    ##2 cal_active_o ##1 filter_word_o == dmrc_pkg::SF_MAX;
  endsequence
  AST_MODE_BOTH: assert property (mode_wr && !en1_only |=> prim_reset_o && aux_reset_o)
    else $error("mode write left a converter running");
  AST_AUX_ONLY: assert property ((mode_wr && en1_only) || (sfr_wr_i
    && sfr_addr_i == dmrc_pkg::CTL1_ADDR) |=> aux_reset_o && !prim_reset_o)
    else $error("auxiliary-only reset wrong");
  AST_CTL0_BOTH: assert property (sfr_wr_i && sfr_addr_i == dmrc_pkg::CTL0_ADDR
    && primary_converter_enable_o |=> prim_reset_o && aux_reset_o)
    else $error("primary control write did not reset both");
  AST_CAL_START: assert property (mode_wr && sfr_wdata_i[2] |-> s_cal_run)
    else $error("calibration start or filter word wrong");
  AST_CAL_END: assert property (s_cal_end |=> !cal_active_o ##1 conversion_mode_field_o == 3'h0)
    else $error("calibration end did not return to power-down");
  AST_PRIM_COEF: assert property (s_cal_end and primary_converter_enable_o
    |=> ($past(cal_kind_o[0]) ? prim_gain_wr_o : prim_ofs_wr_o))
    else $error("primary coefficient write missing");
  AST_AUX_TEMP: assert property (s_cal_end and auxiliary_converter_enable_o
    && auxiliary_converter_control_o[5:4] == dmrc_pkg::ACH_TEMP |=> !aux_ofs_wr_o && !aux_gain_wr_o)
    else $error("temperature calibration wrote coefficients");
  AST_AUX_ALIGN: assert property ($fell(aux_hold_o) |-> $past(prim_out_i))
    else $error("auxiliary released off primary phase");
  AST_FIELDS: assert property (sfr_wr_i && sfr_addr_i == dmrc_pkg::CTL0_ADDR
    |=> {primary_external_reference_select_o, primary_input_pair_select_o,
    primary_unipolar_coding_o, primary_range_select_o} == $past(sfr_wdata_i[6:0]))
    else $error("primary fields wrong");
  AST_SINGLE: assert property (prim_out_i && primary_converter_enable_o && !sfr_wr_i
    && conversion_mode_field_o == dmrc_pkg::MD_SINGLE |=> conversion_mode_field_o == 3'h0)
    else $error("single conversion did not power down");
endmodule // dmrc_top_asserts
bind dmrc_top dmrc_top_asserts u_dmrc_top_asserts (
  .mclk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .prim_out_i, .cal_done_i,
  .prim_reset_o, .aux_reset_o, .aux_hold_o, .conversion_mode_field_o,
  .primary_converter_enable_o, .auxiliary_converter_enable_o, .filter_word_o,
  .primary_external_reference_select_o, .primary_input_pair_select_o,
  .primary_unipolar_coding_o, .primary_range_select_o, .auxiliary_converter_control_o,
  .cal_active_o, .cal_kind_o, .prim_ofs_wr_o, .prim_gain_wr_o, .aux_ofs_wr_o, .aux_gain_wr_o
);
`default_nettype wire

// ---- verif/dual_adc_mode_reset_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module dual_adc_mode_reset_control_test;
  logic       mclk_i = 1'b0, reset_n_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, slow = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, filter_rate_word_i = 8'h00, d;
  logic [7:0] sfr_rdata_o, filter_word_o, auxiliary_converter_control_o;
  logic [2:0] conversion_mode_field_o, primary_range_select_o;
  logic [1:0] primary_input_pair_select_o, cal_kind_o, seen_rst = 2'h0;
  logic       prim_out_i, aux_out_i, cal_done_i, prim_reset_o, aux_reset_o, aux_hold_o;
  logic       aux_valid_o, primary_converter_enable_o, auxiliary_converter_enable_o;
  logic       primary_external_reference_select_o, primary_unipolar_coding_o, cal_active_o;
  logic       prim_ofs_wr_o, prim_gain_wr_o, aux_ofs_wr_o, aux_gain_wr_o, rd_take = 1'b0, p_d;
  logic [3:0] seen_cw = 4'h0;
  logic       clr_seen = 1'b0;
  logic [7:0] expq[$];
  int         err_count = 0, checks_done = 0;
  wire logic [7:0] fields = {1'b0, primary_external_reference_select_o,
    primary_input_pair_select_o, primary_unipolar_coding_o, primary_range_select_o};
  dmrc_top u_dmrc_top (
    .mclk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
    .filter_rate_word_i, .prim_out_i, .aux_out_i, .cal_done_i, .prim_reset_o, .aux_reset_o,
    .aux_hold_o, .aux_valid_o, .conversion_mode_field_o, .primary_converter_enable_o,
    .auxiliary_converter_enable_o, .filter_word_o, .primary_external_reference_select_o,
    .primary_input_pair_select_o, .primary_unipolar_coding_o, .primary_range_select_o,
    .auxiliary_converter_control_o, .cal_active_o, .cal_kind_o, .prim_ofs_wr_o,
    .prim_gain_wr_o, .aux_ofs_wr_o, .aux_gain_wr_o
  );
  dmrc_filter_model u_dmrc_filter_model (
    .mclk_i, .reset_n_i, .slow_i(slow), .cal_i(cal_active_o),
    .prim_run_i(primary_converter_enable_o && conversion_mode_field_o[2:1] == 2'h1),
    .aux_run_i(auxiliary_converter_enable_o && conversion_mode_field_o[2:1] == 2'h1),
    .prim_out_o(prim_out_i), .aux_out_o(aux_out_i), .cal_done_o(cal_done_i)
  );
  always #10 mclk_i = ~mclk_i;
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // reads note their expectation; the compare happens when data appears
  always @(posedge mclk_i) begin
    rd_take  <= sfr_rd_i;
    p_d      <= prim_out_i;
    seen_rst <= clr_seen ? 2'h0 : seen_rst | {prim_reset_o, aux_reset_o};
    seen_cw  <= clr_seen ? 4'h0 : seen_cw | {prim_ofs_wr_o, prim_gain_wr_o, aux_ofs_wr_o,
                 aux_gain_wr_o};
  end
  always @(negedge mclk_i) if (rd_take) chk(sfr_rdata_o, expq.pop_front(), "read data");
  // ---------------------------------------------
  // stimulus
  // ---------------------------------------------
  task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] v);
    if (!w) expq.push_back(v);
    @(posedge mclk_i);
    #1;
    clr_seen    = 1'b0;
    sfr_addr_i  = a;
    sfr_wdata_i = v;
    sfr_wr_i    = w;
    sfr_rd_i    = !w;
    @(posedge mclk_i);
    #1;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
  endtask
  task automatic wait_for(input int w, input int lim);
    int n;
    n = 0;
    while (n < lim && !(w == 0 ? conversion_mode_field_o === 3'h0 : w == 1 ?
           aux_hold_o === 1'b1 : aux_valid_o === 1'b1)) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(8'(n < lim), 8'h01, "wait ran out");
  endtask
  logic [7:0] ra[5] = '{8'hD1, 8'hD2, 8'hD3, 8'hD8, 8'hD4};
  logic [7:0] rv[5] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
  logic [7:0] ta[5] = '{8'hD1, 8'hD1, 8'hD1, 8'hD2, 8'hD3};
  logic [7:0] td[5] = '{8'h23, 8'h23, 8'h33, 8'h07, 8'h00};
  logic [1:0] te[5] = '{2'h3, 2'h3, 2'h1, 2'h3, 2'h1};
  logic [7:0] c1[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
  logic [7:0] cm[6] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h15, 8'h14};
  logic [3:0] cw[6] = '{4'h8, 4'h4, 4'h8, 4'h4, 4'h1, 4'h0};
  logic [7:0] cs[6] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h40, 8'h50};
  initial begin
    void'($urandom(32'h25E365A3));
    filter_rate_word_i = 8'($urandom);
    repeat (8) @(posedge mclk_i);
    #1;
    reset_n_i = 1'b1;
    bus(1, 8'hD4, 8'hFF);
    foreach (ra[i]) bus(0, ra[i], rv[i]);
    $display("reset values done");
    repeat (6) begin
      d = 8'($urandom);
      bus(1, 8'hD2, d);
      bus(0, 8'hD2, d & 8'h7F);
      chk(fields, d & 8'h7F, "primary fields");
    end
    chk(filter_word_o, filter_rate_word_i, "filter word");
    $display("primary fields done");
    for (int i = 0; i < 5; i++) begin
      clr_seen = 1'b1;
      bus(1, ta[i], td[i]);
      repeat (2) @(posedge mclk_i);
      #1;
      chk({6'h0, seen_rst}, {6'h0, te[i]}, "converter resets");
    end
    $display("reset cases done");
    slow = 1'b1;
    bus(1, 8'hD3, 8'h08);
    wait_for(1, 4);
    wait_for(2, 400);
    chk({7'h0, p_d}, 8'h01, "auxiliary out of step");
    $display("alignment done");
    slow = 1'b0;
    bus(1, 8'hD1, 8'h00);
    repeat (4) @(posedge mclk_i);
    bus(1, 8'hD8, 8'hFF);
    bus(0, 8'hD8, 8'h00);
    bus(1, 8'hD1, 8'h22);
    wait_for(0, 100);
    bus(0, 8'hD8, 8'h80);
    $display("single conversion done");
    for (int i = 0; i < 6; i++) begin
      bus(1, 8'hD3, c1[i]);
      clr_seen = 1'b1;
      bus(1, 8'hD1, cm[i]);
      bus(0, 8'hD8, 8'h00);
      wait_for(0, 100);
      repeat (2) @(posedge mclk_i);
      chk({4'h0, seen_cw}, {4'h0, cw[i]}, "coefficient writes");
      bus(0, 8'hD8, cs[i]);
    end
    $display("calibration done");
    repeat (2) @(posedge mclk_i);
    give_verdict;
  end
  // the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    give_verdict;
  end
endmodule // dual_adc_mode_reset_control_test
`default_nettype wire
